// [core/dchp_port.sv]
// Shared parallel host bus port with indexed registers, FIFO access and two DMA channels.
`timescale 1ns/1ps
`default_nettype none
`include "dchp_regs.svh"
// Overview of operation
// - Accesses decode from chip select and two address lines only: four locations.
// - Ports 00 host data, 01 host command, 10 device data, 11 device command.
// - Read strobe returns selected data port; write strobe stores command or data.
// - A command phase writes the index, then data phases reach that register.
// - A 32-bit register takes two data phases, low half first then high.
// - Index 27h returns a fixed read-only identification word on host data.
// - Identification high byte is the part type, low byte the silicon version.
// - Channel 1 serves the host FIFO, channel 2 serves the device side.
// - External end of transfer stops the running DMA transfer.
// - Writing the host DMA setup register arms the internal byte counter.
// - Counter equal to the transfer byte count ends the DMA internally.
// - A FIFO index lets successive data phases stream consecutive FIFO words.
// - The transfer byte count only ends DMA transfers; programmed FIFO cycles run unlimited.
// - Each burst starts with a request; acknowledge marks transfers until the end.
// - Bit 2 of the host DMA setup register enables the counter end.
module dchp_port #(
    parameter int FIFO_DEPTH = `DCHP_FIFO_DEPTH,
    parameter logic [7:0] PART_TYPE = 8'hA5,
    parameter logic [7:0] SILICON_REV = 8'h03
) (
    // Clock and reset.
    input wire logic sys_clk_in,
    input wire logic rstn_in,
    // Processor bus.
    input wire logic cs_n_in,
    input wire logic port_select_low_addr_in,
    input wire logic controller_select_addr_in,
    input wire logic rd_n_in,
    input wire logic wr_n_in,
    input wire logic [15:0] data_in,
    output logic [15:0] data_out,
    output logic data_oe_out,
    // DMA handshakes.
    output logic host_side_dma_request_out,
    input wire logic host_side_dma_acknowledge_n_in,
    output logic device_side_dma_request_out,
    input wire logic device_side_dma_acknowledge_n_in,
    input wire logic end_of_transfer_input_n_in,
    // Host side FIFO streams.
    output logic [15:0] host_tx_data_out,
    output logic host_tx_valid_out,
    input wire logic host_tx_ready_in,
    input wire logic [15:0] host_rx_data_in,
    input wire logic host_rx_valid_in,
    output logic host_rx_ready_out,
    // Device side word port.
    output logic [15:0] dev_wdata_out,
    output logic dev_wvalid_out,
    input wire logic [15:0] dev_rdata_in,
    output logic dev_rd_out,
    input wire logic dev_ready_in
);
    logic rd_q;
    logic wr_q;
    logic dma_busy;
    dchp_pkg::dchp_access_t acc;
    logic [7:0] host_cmd;
    logic [7:0] dev_cmd;
    logic host_half;
    dchp_pkg::dchp_dma_setup_t host_setup;
    dchp_pkg::dchp_dma_setup_t dev_setup;
    logic [15:0] host_count;
    logic [15:0] dev_count;
    logic [31:0] scratch;
    logic hd_wr;
    logic hd_rd;
    logic dd_wr;
    logic dd_rd;
    logic [6:0] host_idx;
    logic [6:0] dev_idx;
    logic ch1_xfer;
    logic ch2_xfer;
    logic tx_push;
    logic tx_ready;
    logic rx_pop;
    logic rx_valid;
    logic [15:0] rx_head;
    logic host_restart;
    logic dev_restart;
    logic [15:0] next_rdata;

    // Strobe edges qualified by chip select; an acknowledge owns the strobes.
    assign dma_busy = !host_side_dma_acknowledge_n_in | !device_side_dma_acknowledge_n_in;
    assign acc.rd_fall = rd_q & !rd_n_in & !cs_n_in & !dma_busy;
    assign acc.wr_fall = wr_q & !wr_n_in & !cs_n_in & !dma_busy;
    assign acc.port = {controller_select_addr_in, port_select_low_addr_in};
    assign acc.data = data_in;
    assign host_idx = host_cmd[6:0];
    assign dev_idx = dev_cmd[6:0];
    // Data phases follow the direction bit of the held index.
    assign hd_wr = acc.wr_fall && acc.port == `DCHP_PORT_HC_DATA && host_cmd[`DCHP_CMD_WRITE_BIT];
    assign hd_rd = acc.rd_fall && acc.port == `DCHP_PORT_HC_DATA && !host_cmd[`DCHP_CMD_WRITE_BIT];
    assign dd_wr = acc.wr_fall && acc.port == `DCHP_PORT_DC_DATA && dev_cmd[`DCHP_CMD_WRITE_BIT];
    assign dd_rd = acc.rd_fall && acc.port == `DCHP_PORT_DC_DATA && !dev_cmd[`DCHP_CMD_WRITE_BIT];
    // FIFO words stream under the FIFO index, or move by channel 1.
    assign tx_push = (hd_wr && host_idx == `DCHP_IDX_FIFO) || (ch1_xfer && host_setup.to_dev);
    assign rx_pop = (hd_rd && host_idx == `DCHP_IDX_FIFO && rx_valid) ||
        (ch1_xfer && !host_setup.to_dev);
    assign host_restart = hd_wr && host_idx == `DCHP_IDX_DMA_SETUP;
    assign dev_restart = dd_wr && dev_idx == `DCHP_IDX_DMA_SETUP;

    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            rd_q <= 1'b1;
            wr_q <= 1'b1;
        end else begin
            rd_q <= rd_n_in;
            wr_q <= wr_n_in;
        end
    end

    // Command ports keep the index until the next command write.
    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            host_cmd <= `DCHP_RST_CMD;
            dev_cmd <= `DCHP_RST_CMD;
        end else if (acc.wr_fall) begin
            if (acc.port == `DCHP_PORT_HC_CMD) begin
                host_cmd <= acc.data[7:0];
            end
            if (acc.port == `DCHP_PORT_DC_CMD) begin
                dev_cmd <= acc.data[7:0];
            end
        end
    end

    // Half select of the 32-bit register: low half first after each command.
    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            host_half <= 1'b0;
        end else if (acc.wr_fall && acc.port == `DCHP_PORT_HC_CMD) begin
            host_half <= 1'b0;
        end else if ((hd_wr || hd_rd) && host_idx == `DCHP_IDX_SCRATCH32) begin
            host_half <= !host_half;
        end
    end

    // Writable host registers.
    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            host_setup <= `DCHP_RST_WORD;
            host_count <= `DCHP_RST_WORD;
            scratch <= {`DCHP_RST_WORD, `DCHP_RST_WORD};
        end else if (hd_wr) begin
            case (host_idx)
                `DCHP_IDX_DMA_SETUP: host_setup <= acc.data;
                `DCHP_IDX_XFER_COUNT: host_count <= acc.data;
                `DCHP_IDX_SCRATCH32: begin
                    if (host_half) begin
                        scratch[31:16] <= acc.data;
                    end else begin
                        scratch[15:0] <= acc.data;
                    end
                end
                default: begin
                end
            endcase
        end
    end

    // Device side setup and count for channel 2.
    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            dev_setup <= `DCHP_RST_WORD;
            dev_count <= `DCHP_RST_WORD;
        end else if (dd_wr) begin
            case (dev_idx)
                `DCHP_IDX_DMA_SETUP: dev_setup <= acc.data;
                `DCHP_IDX_XFER_COUNT: dev_count <= acc.data;
                default: begin
                end
            endcase
        end
    end

    // Read data selection, including the fixed identification word.
    always_comb begin
        next_rdata = data_out;
        if (ch1_xfer && !host_setup.to_dev) begin
            next_rdata = rx_head;
        end else if (ch2_xfer && !dev_setup.to_dev) begin
            next_rdata = dev_rdata_in;
        end else if (hd_rd) begin
            case (host_idx)
                `DCHP_IDX_DMA_SETUP: next_rdata = host_setup;
                `DCHP_IDX_XFER_COUNT: next_rdata = host_count;
                `DCHP_IDX_PART_ID: next_rdata = {PART_TYPE, SILICON_REV};
                `DCHP_IDX_SCRATCH32: next_rdata = host_half ? scratch[31:16] : scratch[15:0];
                `DCHP_IDX_FIFO: next_rdata = rx_valid ? rx_head : `DCHP_RST_WORD;
                default: next_rdata = `DCHP_RST_WORD;
            endcase
        end else if (dd_rd) begin
            case (dev_idx)
                `DCHP_IDX_DMA_SETUP: next_rdata = dev_setup;
                `DCHP_IDX_XFER_COUNT: next_rdata = dev_count;
                `DCHP_IDX_FIFO: next_rdata = dev_rdata_in;
                default: next_rdata = `DCHP_RST_WORD;
            endcase
        end
    end

    // Bus drive: only data ports are read, command ports never drive.
    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            data_out <= `DCHP_RST_WORD;
            data_oe_out <= 1'b0;
        end else begin
            data_out <= next_rdata;
            data_oe_out <= (!cs_n_in && !rd_n_in && !port_select_low_addr_in && !dma_busy) ||
                (!host_side_dma_acknowledge_n_in && !host_setup.to_dev) ||
                (!device_side_dma_acknowledge_n_in && !dev_setup.to_dev);
        end
    end

    // Device side words leave as one-cycle strobes.
    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            dev_wdata_out <= `DCHP_RST_WORD;
            dev_wvalid_out <= 1'b0;
            dev_rd_out <= 1'b0;
        end else begin
            dev_wvalid_out <= (dd_wr && dev_idx == `DCHP_IDX_FIFO) || (ch2_xfer && dev_setup.to_dev);
            dev_rd_out <= (dd_rd && dev_idx == `DCHP_IDX_FIFO) || (ch2_xfer && !dev_setup.to_dev);
            if (dd_wr || ch2_xfer) begin
                dev_wdata_out <= acc.data;
            end
        end
    end

    dchp_fifo #(.WIDTH(`DCHP_DATA_W), .DEPTH(FIFO_DEPTH)) u_tx_fifo (
        .sys_clk_in(sys_clk_in),
        .rstn_in(rstn_in),
        .in_valid_in(tx_push),
        .in_ready_out(tx_ready),
        .in_data_in(acc.data),
        .out_valid_out(host_tx_valid_out),
        .out_ready_in(host_tx_ready_in),
        .out_data_out(host_tx_data_out)
    );

    dchp_fifo #(.WIDTH(`DCHP_DATA_W), .DEPTH(FIFO_DEPTH)) u_rx_fifo (
        .sys_clk_in(sys_clk_in),
        .rstn_in(rstn_in),
        .in_valid_in(host_rx_valid_in),
        .in_ready_out(host_rx_ready_out),
        .in_data_in(host_rx_data_in),
        .out_valid_out(rx_valid),
        .out_ready_in(rx_pop),
        .out_data_out(rx_head)
    );

    dchp_dma_chan u_ch1 (
        .sys_clk_in(sys_clk_in),
        .rstn_in(rstn_in),
        .setup_in(host_setup),
        .restart_in(host_restart),
        .byte_count_in(host_count),
        .room_in(host_setup.to_dev ? tx_ready : rx_valid),
        .dack_n_in(host_side_dma_acknowledge_n_in),
        .rd_fall_in(rd_q & !rd_n_in),
        .wr_fall_in(wr_q & !wr_n_in),
        .eot_n_in(end_of_transfer_input_n_in),
        .dreq_out(host_side_dma_request_out),
        .xfer_out(ch1_xfer),
        .done_out()
    );

    dchp_dma_chan u_ch2 (
        .sys_clk_in(sys_clk_in),
        .rstn_in(rstn_in),
        .setup_in(dev_setup),
        .restart_in(dev_restart),
        .byte_count_in(dev_count),
        .room_in(dev_ready_in),
        .dack_n_in(device_side_dma_acknowledge_n_in),
        .rd_fall_in(rd_q & !rd_n_in),
        .wr_fall_in(wr_q & !wr_n_in),
        .eot_n_in(end_of_transfer_input_n_in),
        .dreq_out(device_side_dma_request_out),
        .xfer_out(ch2_xfer),
        .done_out()
    );

    a_id_read_word: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
        hd_rd && host_cmd == {1'b0, `DCHP_IDX_PART_ID} |=> data_out == {PART_TYPE, SILICON_REV})
        else $error("identification word not returned");
    a_cmd_index_held: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
        !(acc.wr_fall && acc.port == `DCHP_PORT_HC_CMD) |=> $stable(host_cmd))
        else $error("host command index changed without a command write");
    a_cmd_index_load: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
        acc.wr_fall && acc.port == `DCHP_PORT_DC_CMD |=> dev_cmd == $past(data_in[7:0]))
        else $error("device command index not stored");
    a_setup_write_dir: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
        acc.wr_fall && acc.port == `DCHP_PORT_HC_DATA && host_cmd == 8'h21 |=> $stable(host_setup))
        else $error("read index accepted a write");
    a_half_order: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
        hd_wr && host_idx == `DCHP_IDX_SCRATCH32 && host_half |=>
        scratch[31:16] == $past(data_in))
        else $error("second data phase did not reach the upper half");
    a_cs_gates_cmd: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
        cs_n_in && !device_side_dma_acknowledge_n_in |=> $stable(dev_cmd) && $stable(host_cmd))
        else $error("command changed without chip select");
    a_fifo_stream: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
        hd_wr && host_idx == `DCHP_IDX_FIFO && tx_ready && !host_tx_valid_out |=>
        host_tx_valid_out && host_tx_data_out == $past(data_in))
        else $error("FIFO data phase did not reach the buffer");
endmodule
`default_nettype wire

// [common/dchp_regs.svh]
// Register indices, field positions, reset values and sizes of the host bus port.
`ifndef DCHP_REGS_SVH
`define DCHP_REGS_SVH
`define DCHP_PORT_HC_DATA 2'h0
`define DCHP_PORT_HC_CMD 2'h1
`define DCHP_PORT_DC_DATA 2'h2
`define DCHP_PORT_DC_CMD 2'h3
`define DCHP_IDX_DMA_SETUP 7'h21
`define DCHP_IDX_XFER_COUNT 7'h22
`define DCHP_IDX_PART_ID 7'h27
`define DCHP_IDX_SCRATCH32 7'h28
`define DCHP_IDX_FIFO 7'h40
`define DCHP_CMD_WRITE_BIT 7
`define DCHP_SETUP_EN_BIT 0
`define DCHP_SETUP_DIR_BIT 1
`define DCHP_SETUP_CNT_BIT 2
`define DCHP_SETUP_ACK_BIT 3
`define DCHP_RST_WORD 16'h0000
`define DCHP_RST_CMD 8'h00
`define DCHP_BYTES_PER_WORD 16'h0002
`define DCHP_DATA_W 16
`define DCHP_FIFO_DEPTH 16
`endif

// [common/dchp_pkg.sv]
// Types shared by the host bus port modules.
package dchp_pkg;
    // Layout of a DMA setup register.
    typedef struct packed {
        logic [11:0] rsvd;
        logic ack_only;
        logic cnt_en;
        logic to_dev;
        logic en;
    } dchp_dma_setup_t;

    typedef enum logic [1:0] {
        DCHP_CH_IDLE = 2'b00,
        DCHP_CH_REQ = 2'b01,
        DCHP_CH_DONE = 2'b10
    } dchp_ch_state_t;

    // One decoded bus strobe event.
    typedef struct packed {
        logic rd_fall;
        logic wr_fall;
        logic [1:0] port;
        logic [15:0] data;
    } dchp_access_t;
endpackage

// [core/dchp_fifo.sv]
// Word FIFO with registered head data and registered flags.
`timescale 1ns/1ps
`default_nettype none
module dchp_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 16
) (
    // Clock and reset.
    input wire logic sys_clk_in,
    input wire logic rstn_in,
    // Filling side.
    input wire logic in_valid_in,
    output logic in_ready_out,
    input wire logic [WIDTH-1:0] in_data_in,
    // Draining side.
    output logic out_valid_out,
    input wire logic out_ready_in,
    output logic [WIDTH-1:0] out_data_out
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wptr;
    logic [AW-1:0] rptr;
    logic [AW:0] count;
    logic push;
    logic pop;
    logic [AW-1:0] next_rptr;
    logic [AW:0] next_count;

    assign push = in_valid_in & in_ready_out;
    assign pop = out_ready_in & out_valid_out;
    assign next_rptr = pop ? rptr + 1'b1 : rptr;
    assign next_count = count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};

    always_ff @(posedge sys_clk_in) begin
        if (push) begin
            mem[wptr] <= in_data_in;
        end
    end

    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            wptr <= '0;
            rptr <= '0;
            count <= '0;
            in_ready_out <= 1'b1;
            out_valid_out <= 1'b0;
        end else begin
            wptr <= push ? wptr + 1'b1 : wptr;
            rptr <= next_rptr;
            count <= next_count;
            in_ready_out <= (next_count != DEPTH[AW:0]);
            out_valid_out <= (next_count != '0);
        end
    end

    // The head register follows the read pointer; a write into the head slot bypasses memory.
    // It holds while the buffer is empty, so unwritten slots never reach the output.
    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            out_data_out <= '0;
        end else if (push && wptr == next_rptr) begin
            out_data_out <= in_data_in;
        end else if (next_count != '0) begin
            out_data_out <= mem[next_rptr];
        end
    end
endmodule
`default_nettype wire

// [core/dchp_dma_chan.sv]
// One DMA channel: request, acknowledge qualification and end-of-transfer.
`timescale 1ns/1ps
`default_nettype none
`include "dchp_regs.svh"
module dchp_dma_chan (
    // Clock and reset.
    input wire logic sys_clk_in,
    input wire logic rstn_in,
    // Setup.
    input wire dchp_pkg::dchp_dma_setup_t setup_in,
    input wire logic restart_in,
    input wire logic [15:0] byte_count_in,
    input wire logic room_in,
    // Master side.
    input wire logic dack_n_in,
    input wire logic rd_fall_in,
    input wire logic wr_fall_in,
    input wire logic eot_n_in,
    output logic dreq_out,
    output logic xfer_out,
    output logic done_out
);
    dchp_pkg::dchp_ch_state_t state;
    logic dack_q;
    logic [15:0] bytes;
    logic [15:0] next_bytes;
    logic hit;

    assign xfer_out = (state == dchp_pkg::DCHP_CH_REQ) &&
        (setup_in.ack_only ? (dack_q & !dack_n_in) :
        (!dack_n_in && (setup_in.to_dev ? wr_fall_in : rd_fall_in)));
    assign next_bytes = bytes + `DCHP_BYTES_PER_WORD;
    assign hit = setup_in.cnt_en && xfer_out && next_bytes == byte_count_in;
    assign done_out = state == dchp_pkg::DCHP_CH_DONE;

    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            dack_q <= 1'b1;
        end else begin
            dack_q <= dack_n_in;
        end
    end

    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            state <= dchp_pkg::DCHP_CH_IDLE;
            bytes <= `DCHP_RST_WORD;
        end else if (restart_in) begin
            state <= dchp_pkg::DCHP_CH_IDLE;
            bytes <= `DCHP_RST_WORD;
        end else begin
            case (state)
                dchp_pkg::DCHP_CH_IDLE: begin
                    if (setup_in.en) begin
                        state <= dchp_pkg::DCHP_CH_REQ;
                    end
                end
                dchp_pkg::DCHP_CH_REQ: begin
                    if (xfer_out) begin
                        bytes <= next_bytes;
                    end
                    if (!eot_n_in || hit) begin
                        state <= dchp_pkg::DCHP_CH_DONE;
                    end
                end
                dchp_pkg::DCHP_CH_DONE: begin
                    if (!setup_in.en) begin
                        state <= dchp_pkg::DCHP_CH_IDLE;
                        bytes <= `DCHP_RST_WORD;
                    end
                end
                default: begin
                    state <= dchp_pkg::DCHP_CH_IDLE;
                end
            endcase
        end
    end

    // The request stands through the burst while there is room or data to move.
    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            dreq_out <= 1'b0;
        end else begin
            dreq_out <= state == dchp_pkg::DCHP_CH_REQ && eot_n_in && !hit &&
                room_in && !restart_in;
        end
    end

    a_eot_stops_req: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
        !eot_n_in |=> !dreq_out)
        else $error("request still raised after end of transfer");
    a_count_stops_req: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
        hit && !restart_in |=> done_out && !dreq_out ##1 !dreq_out)
        else $error("byte count reached but request went on");
endmodule
`default_nettype wire

// [sim/dchp_dma_master.sv]
// System DMA master model that answers one channel request in acknowledge-only mode.
`timescale 1ns/1ps
`default_nettype none
module dchp_dma_master (
    // Clock and reset.
    input wire logic sys_clk_in,
    input wire logic rstn_in,
    // Channel handshake.
    input wire logic go_in,
    input wire logic dreq_in,
    output logic dack_n_out,
    output logic [15:0] data_out
);
    logic [15:0] word;
    // Every low acknowledge cycle carries one word; outside it the bus shows changing junk.
    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            dack_n_out <= 1'b1;
            data_out <= 16'h0000;
            word <= 16'hD000;
        end else if (go_in && dreq_in && dack_n_out) begin
            dack_n_out <= 1'b0;
            data_out <= word;
            word <= word + 16'h0001;
        end else begin
            dack_n_out <= 1'b1;
            data_out <= ~data_out;
        end
    end
endmodule
`default_nettype wire

// [sim/testbench.sv]
// Self-checking bench for the shared host bus port.
`timescale 1ns/1ps
`default_nettype none
`include "dchp_regs.svh"
module testbench;
    localparam logic [1:0] HD = `DCHP_PORT_HC_DATA;
    localparam logic [1:0] HC = `DCHP_PORT_HC_CMD;
    localparam logic [1:0] DD = `DCHP_PORT_DC_DATA;
    localparam logic [1:0] DC = `DCHP_PORT_DC_CMD;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic cs_n = 1'b1;
    logic [1:0] adr = 2'h0;
    logic rd_n = 1'b1;
    logic wr_n = 1'b1;
    logic [15:0] b_data = 16'h0000;
    logic eot_n = 1'b1;
    logic tx_rdy = 1'b0;
    logic [15:0] rx_data = 16'h0000;
    logic rx_val = 1'b0;
    logic dev_rdy = 1'b0;
    logic go = 1'b0;
    logic go2 = 1'b0;
    logic nrm = 1'b0;
    logic [15:0] dev_rd = 16'h5A5A;
    logic [15:0] q, m_data, dout, txd, dev_wd, bus;
    logic oe, h_dreq, h_dack_n, d_dreq, txv, rxr, dev_wv, d_dack_n, dev_re;
    logic [15:0] tx_q[$];
    logic [15:0] dev_last = 16'h0000;
    int fails = 0;
    int checks = 0;
    int dev_rds = 0;
    int i;
    assign bus = h_dack_n ? b_data : m_data;
    initial begin
        forever #25 clk = ~clk;
    end
    dchp_port #(.FIFO_DEPTH(16), .PART_TYPE(8'hA5), .SILICON_REV(8'h03)) dut_u (
        .sys_clk_in(clk), .rstn_in(rstn), .cs_n_in(cs_n), .port_select_low_addr_in(adr[0]),
        .controller_select_addr_in(adr[1]), .rd_n_in(rd_n), .wr_n_in(wr_n & (h_dack_n | !nrm)),
        .data_in(bus), .data_out(dout), .data_oe_out(oe), .host_side_dma_request_out(h_dreq),
        .host_side_dma_acknowledge_n_in(h_dack_n), .device_side_dma_request_out(d_dreq),
        .device_side_dma_acknowledge_n_in(d_dack_n), .end_of_transfer_input_n_in(eot_n),
        .host_tx_data_out(txd), .host_tx_valid_out(txv), .host_tx_ready_in(tx_rdy),
        .host_rx_data_in(rx_data), .host_rx_valid_in(rx_val), .host_rx_ready_out(rxr),
        .dev_wdata_out(dev_wd), .dev_wvalid_out(dev_wv), .dev_rdata_in(dev_rd),
        .dev_rd_out(dev_re), .dev_ready_in(dev_rdy));
    dchp_dma_master pm_u (.sys_clk_in(clk), .rstn_in(rstn), .go_in(go), .dreq_in(h_dreq),
        .dack_n_out(h_dack_n), .data_out(m_data));
    dchp_dma_master pm2_u (.sys_clk_in(clk), .rstn_in(rstn), .go_in(go2), .dreq_in(d_dreq),
        .dack_n_out(d_dack_n), .data_out());
    always @(posedge clk) begin
        if (txv && tx_rdy) tx_q.push_back(txd);
        if (dev_wv) dev_last <= dev_wd;
        if (dev_re) dev_rds++;
    end
    task automatic chkw(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("Error at %0t: word %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chkb(input logic got, input logic exp);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("Error at %0t: flag %b expected %b", $time, got, exp);
        end
    endtask
    // One strobe held for three edges, then one idle cycle before the next access.
    task automatic acc(input logic [1:0] a, input logic rd, input logic [15:0] d);
        @(posedge clk);
        cs_n <= 1'b0;
        adr <= a;
        b_data <= d;
        rd_n <= !rd;
        wr_n <= rd;
        repeat (3) @(posedge clk);
        cs_n <= 1'b1;
        rd_n <= 1'b1;
        wr_n <= 1'b1;
        @(negedge clk);
        q = dout;
    endtask
    task automatic wreg(input logic [1:0] c, input logic [7:0] idx, input logic [15:0] v);
        acc(c, 1'b0, {8'h00, idx});
        acc(c - 2'h1, 1'b0, v);
    endtask
    task automatic rreg(input logic [1:0] c, input logic [7:0] idx, input logic [15:0] e);
        acc(c, 1'b0, {8'h00, idx});
        acc(c - 2'h1, 1'b1, 16'h0000);
        chkw(q, e);
    endtask
    task automatic waitq(input logic lvl);
        for (int n = 0; n < 40 && h_dreq !== lvl; n++) @(negedge clk);
        chkb(h_dreq, lvl);
    endtask
    task automatic final_report();
        $display("Checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clk);
        fails++;
        final_report();
    end
    initial begin
        repeat (5) @(posedge clk);
        rstn <= 1'b1;
        repeat (2) @(negedge clk);
        chkb(rxr, 1'b1);
        rreg(HC, 8'h27, {8'hA5, 8'h03});
        acc(HC, 1'b1, 16'h0000);
        chkb(oe, 1'b0);
        acc(HD, 1'b1, 16'h0000);
        chkw(q, 16'hA503);
        wreg(HC, 8'hA2, 16'h0022);
        rreg(HC, 8'h22, 16'h0022);
        wreg(HC, 8'hA8, 16'h1234);
        acc(HD, 1'b0, 16'h5678);
        acc(HC, 1'b0, 16'h0028);
        acc(HD, 1'b1, 16'h0000);
        chkw(q, 16'h1234);
        acc(HD, 1'b1, 16'h0000);
        chkw(q, 16'h5678);
        for (i = 0; i < 16; i++) begin
            @(posedge clk);
            rx_val <= 1'b1;
            rx_data <= 16'h0100 + i[15:0];
            do @(negedge clk); while (rxr !== 1'b1);
        end
        @(posedge clk);
        rx_val <= 1'b0;
        @(negedge clk);
        chkb(rxr, 1'b0);
        acc(HC, 1'b0, 16'h0040);
        for (i = 0; i < 17; i++) begin
            acc(HD, 1'b1, 16'h0000);
            chkw(q, (i < 16) ? 16'h0100 + i[15:0] : 16'h0000);
        end
        acc(HC, 1'b0, 16'h00C0);
        for (i = 0; i < 17; i++) acc(HD, 1'b0, 16'hE000 + i[15:0]);
        for (i = 0; i < 40; i++) begin
            @(posedge clk);
            tx_rdy <= i[0];
        end
        chkw(16'(tx_q.size()), 16'h0010);
        chkw(tx_q[15], 16'hE00F);
        @(posedge clk);
        tx_rdy <= 1'b1;
        tx_q.delete();
        wreg(HC, 8'hA2, 16'h0004);
        wreg(HC, 8'hA1, 16'h000F);
        waitq(1'b1);
        @(posedge clk);
        go <= 1'b1;
        waitq(1'b0);
        repeat (2) @(negedge clk);
        chkw(16'(tx_q.size()), 16'h0002);
        chkw(tx_q[1], 16'hD001);
        go <= 1'b0;
        wreg(HC, 8'hA1, 16'h000B);
        waitq(1'b1);
        @(posedge clk);
        go <= 1'b1;
        repeat (6) @(posedge clk);
        eot_n <= 1'b0;
        waitq(1'b0);
        @(posedge clk);
        eot_n <= 1'b1;
        go <= 1'b0;
        dev_rdy <= 1'b1;
        acc(HC, 1'b0, 16'h0021);
        acc(HD, 1'b0, 16'hFFFF);
        acc(HD, 1'b1, 16'h0000);
        chkw(q, 16'h000B);
        nrm <= 1'b1;
        wreg(HC, 8'hA1, 16'h0007);
        tx_q.delete();
        waitq(1'b1);
        @(posedge clk);
        go <= 1'b1;
        waitq(1'b0);
        repeat (2) @(negedge clk);
        chkw(16'(tx_q.size()), 16'h0002);
        go <= 1'b0;
        nrm <= 1'b0;
        acc(DC, 1'b0, 16'h00C0);
        acc(DD, 1'b0, 16'h0BEE);
        chkw(dev_last, 16'h0BEE);
        rreg(DC, 8'h40, 16'h5A5A);
        dev_rd <= 16'hC3C3;
        wreg(DC, 8'hA2, 16'h0006);
        wreg(DC, 8'hA1, 16'h000D);
        repeat (3) @(negedge clk);
        chkb(d_dreq, 1'b1);
        chkb(h_dreq, 1'b0);
        go2 <= 1'b1;
        for (i = 0; i < 40 && d_dreq === 1'b1; i++) @(negedge clk);
        repeat (2) @(negedge clk);
        chkb(d_dreq, 1'b0);
        chkw(dout, 16'hC3C3);
        chkw(16'(dev_rds), 16'h0004);
        final_report();
    end
endmodule
`default_nettype wire
